// File: verilog/ual_consts.svh
// register map, bit positions and timing counts of the serial status block
`ifndef UAL_CONSTS_SVH
`define UAL_CONSTS_SVH

`define UAL_ADDR_MCR      32'h4000_8010
`define UAL_ADDR_LSR      32'h4000_8014
`define UAL_ADDR_IER      32'h4000_8044
`define UAL_ADDR_MSR      32'h4000_8048
`define UAL_ADDR_FCR      32'h4000_804c
`define UAL_ADDR_IRQ_STAT 32'h4000_8050
`define UAL_ADDR_IRQ_MASK 32'h4000_8054

`define UAL_MCR_AUTO_CTS 7
`define UAL_IER_MS       3
`define UAL_IER_CTS      7
`define UAL_FCR_FIFO_EN  0

`define UAL_LSR_RDR 0
`define UAL_LSR_OE  1
`define UAL_LSR_PE  2

`define UAL_MSR_DCTS 0
`define UAL_MSR_DDSR 1
`define UAL_MSR_TERI 2
`define UAL_MSR_DDCD 3
`define UAL_MSR_CTS  4
`define UAL_MSR_DSR  5
`define UAL_MSR_RI   6
`define UAL_MSR_DCD  7

`define UAL_IRQ_RDA 0
`define UAL_IRQ_OE  1
`define UAL_IRQ_PE  2
`define UAL_IRQ_MS  3
`define UAL_IRQ_W   4

`define UAL_REG_RST   8'h00
`define UAL_BAUD_DIV  16
`define UAL_DATA_BITS 8
`define UAL_SYNC_RST  1'b1

`endif

// File: verilog/ual_pkg.sv
// shared types of the serial status block
package ual_pkg;

    typedef enum logic [3:0] {
        tx_idle  = 4'b0001,
        tx_start = 4'b0010,
        tx_data  = 4'b0100,
        tx_stop  = 4'b1000
    } ual_tx_state_e;

endpackage

// File: verilog/ual_tx_if.sv
// carrier between the top and the flow-gated transmitter
interface ual_tx_if;
    logic auto_en;
    logic cts_n;
    logic valid;
    logic [7:0] data;
    logic take;
    logic txd;

    modport top (output auto_en, output cts_n, output valid, output data,
                 input take, input txd);
    modport gate (input auto_en, input cts_n, input valid, input data,
                  output take, output txd);
endinterface

// File: verilog/ual_sync.sv
// three-stage pin synchroniser with agreement filter, one per bit
`include "ual_consts.svh"
module ual_sync #(
    parameter int W = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    s1_q <= `UAL_SYNC_RST;
                    s2_q <= `UAL_SYNC_RST;
                    s3_q <= `UAL_SYNC_RST;
                    o_level[g] <= `UAL_SYNC_RST;
                end else begin
                    s1_q <= i_pin[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // a change counts only once stages two and three agree
                    if (s2_q == s3_q) begin
                        o_level[g] <= s3_q;
                    end
                end
            end
        end
    endgenerate
endmodule

// File: verilog/ual_tx_gate.sv
// 8n1 serialiser whose byte starts are gated by the cts line
`include "ual_consts.svh"
module ual_tx_gate #(
    parameter int BAUD_DIV = `UAL_BAUD_DIV
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    ual_tx_if.gate tx
);
    localparam int CW = $clog2(BAUD_DIV + 1);
    localparam logic [CW-1:0] DIV_END = CW'(BAUD_DIV - 1);
    localparam logic [CW-1:0] DIV_MID = CW'(BAUD_DIV / 2);
    localparam logic [2:0] LAST_BIT = 3'(`UAL_DATA_BITS - 1);

    ual_pkg::ual_tx_state_e state_q;
    logic [CW-1:0] div_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic go_q;
    logic go;

    // without auto mode the line is ignored entirely
    assign go = !tx.auto_en || !tx.cts_n;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q <= ual_pkg::tx_idle;
            div_q <= '0;
            bit_q <= '0;
            shift_q <= '0;
            go_q <= 1'b0;
            tx.take <= 1'b0;
            tx.txd <= 1'b1;
        end else begin
            tx.take <= 1'b0;
            div_q <= (div_q == DIV_END) ? '0 : div_q + 1'b1;
            case (state_q)
                ual_pkg::tx_idle: begin
                    tx.txd <= 1'b1;
                    div_q <= '0;
                    if (tx.valid && go) begin
                        tx.take <= 1'b1;
                        shift_q <= tx.data;
                        tx.txd <= 1'b0;
                        state_q <= ual_pkg::tx_start;
                    end
                end
                ual_pkg::tx_start: begin
                    if (div_q == DIV_END) begin
                        tx.txd <= shift_q[0];
                        bit_q <= '0;
                        state_q <= ual_pkg::tx_data;
                    end
                end
                ual_pkg::tx_data: begin
                    if (div_q == DIV_END) begin
                        if (bit_q == LAST_BIT) begin
                            tx.txd <= 1'b1;
                            state_q <= ual_pkg::tx_stop;
                        end else begin
                            tx.txd <= shift_q[bit_q + 3'd1];
                            bit_q <= bit_q + 3'd1;
                        end
                    end
                end
                ual_pkg::tx_stop: begin
                    // decision for the next byte is taken mid stop bit
                    if (div_q == DIV_MID) begin
                        go_q <= go;
                    end
                    if (div_q == DIV_END) begin
                        if (tx.valid && go_q) begin
                            tx.take <= 1'b1;
                            shift_q <= tx.data;
                            tx.txd <= 1'b0;
                            state_q <= ual_pkg::tx_start;
                        end else begin
                            state_q <= ual_pkg::tx_idle;
                        end
                    end
                end
                default: begin
                    state_q <= ual_pkg::tx_idle;
                end
            endcase
        end
    end
endmodule

// File: verilog/ual_top.sv
// cts flow gating, modem status interrupt and low line status flags
// Summary of operation
// - in auto mode, cts is sampled before each new byte starts
// - in auto mode, the next byte starts only if cts was low in idle or at mid stop bit
// - in auto mode cts change sets delta flag; interrupt needs cts enable
// - modem interrupt never fires while its enable bit is clear
// - modem interrupt from dcd, ri, dsr deltas, or gated delta cts
// - negated cts: finish current char, hold line at one, then resume
// - auto mode off: send everything queued regardless of cts
// - data ready follows an unread character; clears when fifo empties
// - char done into full fifo: set overrun, drop new char, keep fifo
// - reading line status clears overrun
// - bad parity sets parity error; line status read clears it
// - parity error belongs to fifo head; timing follows fifo enable
// - auto flow enable is bit 7 of the modem control register
`include "ual_consts.svh"
module ual_top #(
    parameter int BAUD_DIV = `UAL_BAUD_DIV
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // register port
    input wire logic [31:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // modem pins, active low
    input wire logic i_cts_n,
    input wire logic i_dsr_n,
    input wire logic i_dcd_n,
    input wire logic i_ri_n,
    // transmit fifo and serial output
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_pop,
    output logic o_txd,
    // receive shift register and fifo
    input wire logic i_rx_done,
    input wire logic i_rx_parity_bad,
    input wire logic i_rx_fifo_full,
    input wire logic i_rx_fifo_empty,
    input wire logic i_rx_head_new,
    input wire logic i_rx_head_parity_bad,
    output logic o_rx_push,
    // interrupts
    output logic o_modem_int,
    output logic o_irq
);
    logic [7:0] interrupt_enable_reg_q;
    logic [7:0] modem_control_reg_q;
    logic [7:0] fifo_control_reg_q;
    logic [`UAL_IRQ_W-1:0] irq_mask_q;
    logic [`UAL_IRQ_W-1:0] irq_stat_q;
    logic [`UAL_IRQ_W-1:0] irq_stat_d;
    logic [`UAL_IRQ_W-1:0] irq_event;
    logic [3:0] delta_q;
    logic [3:0] pins_prev_q;
    logic [3:0] pins_sync;
    logic rx_data_ready_q;
    logic overrun_q;
    logic parity_error_q;
    logic ms_int_d;
    logic auto_tx_flow_enable;
    logic wr_hit_lsr;
    logic rd_lsr;
    logic rd_msr;
    logic oe_set;
    logic pe_set;
    logic [7:0] modem_status_reg;
    logic [7:0] line_status_reg;

    ual_tx_if tx ();

    // pin order: cts, dsr, ri, dcd
    ual_sync #(
        .W(4)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_pin({i_dcd_n, i_ri_n, i_dsr_n, i_cts_n}),
        .o_level(pins_sync)
    );

    ual_tx_gate #(
        .BAUD_DIV(BAUD_DIV)
    ) u_tx (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .tx(tx.gate)
    );

    assign auto_tx_flow_enable =
        modem_control_reg_q[`UAL_MCR_AUTO_CTS];
    assign tx.auto_en = auto_tx_flow_enable;
    assign tx.cts_n = pins_sync[0];
    assign tx.valid = i_tx_valid;
    assign tx.data = i_tx_data;

    assign rd_lsr = i_reg_rd && (i_reg_addr == `UAL_ADDR_LSR);
    assign rd_msr = i_reg_rd && (i_reg_addr == `UAL_ADDR_MSR);
    assign wr_hit_lsr = i_reg_wr && (i_reg_addr == `UAL_ADDR_LSR);

    // line status is read only; writes to it fall away
    assign line_status_reg = {5'h00, parity_error_q, overrun_q,
                              rx_data_ready_q};
    // state half shows the pins active high
    assign modem_status_reg = {~pins_sync[3], ~pins_sync[2],
                               ~pins_sync[1], ~pins_sync[0], delta_q};

    // writable control registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            interrupt_enable_reg_q <= `UAL_REG_RST;
            modem_control_reg_q <= `UAL_REG_RST;
            fifo_control_reg_q <= `UAL_REG_RST;
            irq_mask_q <= '0;
        end else if (i_reg_wr && !wr_hit_lsr) begin
            if (i_reg_addr == `UAL_ADDR_IER) begin
                interrupt_enable_reg_q <= i_reg_wdata[7:0];
            end else if (i_reg_addr == `UAL_ADDR_MCR) begin
                modem_control_reg_q <= i_reg_wdata[7:0];
            end else if (i_reg_addr == `UAL_ADDR_FCR) begin
                fifo_control_reg_q <= i_reg_wdata[7:0];
            end else if (i_reg_addr == `UAL_ADDR_IRQ_MASK) begin
                irq_mask_q <= i_reg_wdata[`UAL_IRQ_W-1:0];
            end
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_reg_rdata <= '0;
        end else if (!i_reg_rd) begin
            o_reg_rdata <= '0;
        end else if (i_reg_addr == `UAL_ADDR_LSR) begin
            o_reg_rdata <= {24'h000000, line_status_reg};
        end else if (i_reg_addr == `UAL_ADDR_MSR) begin
            o_reg_rdata <= {24'h000000, modem_status_reg};
        end else if (i_reg_addr == `UAL_ADDR_IER) begin
            o_reg_rdata <= {24'h000000, interrupt_enable_reg_q};
        end else if (i_reg_addr == `UAL_ADDR_MCR) begin
            o_reg_rdata <= {24'h000000, modem_control_reg_q};
        end else if (i_reg_addr == `UAL_ADDR_FCR) begin
            o_reg_rdata <= {24'h000000, fifo_control_reg_q};
        end else if (i_reg_addr == `UAL_ADDR_IRQ_STAT) begin
            o_reg_rdata <= {28'h0000000, irq_stat_q};
        end else if (i_reg_addr == `UAL_ADDR_IRQ_MASK) begin
            o_reg_rdata <= {28'h0000000, irq_mask_q};
        end else begin
            o_reg_rdata <= '0;
        end
    end

    // modem deltas: sticky, cleared by a status read, a new edge wins
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pins_prev_q <= 4'hf;
            delta_q <= 4'h0;
        end else begin
            pins_prev_q <= pins_sync;
            // delta cts is set in auto mode too
            delta_q[`UAL_MSR_DCTS] <= (pins_sync[0] != pins_prev_q[0])
                || (delta_q[`UAL_MSR_DCTS] && !rd_msr);
            delta_q[`UAL_MSR_DDSR] <= (pins_sync[1] != pins_prev_q[1])
                || (delta_q[`UAL_MSR_DDSR] && !rd_msr);
            // ring indicator only flags its trailing edge
            delta_q[`UAL_MSR_TERI] <= (pins_sync[2] && !pins_prev_q[2])
                || (delta_q[`UAL_MSR_TERI] && !rd_msr);
            delta_q[`UAL_MSR_DDCD] <= (pins_sync[3] != pins_prev_q[3])
                || (delta_q[`UAL_MSR_DDCD] && !rd_msr);
        end
    end

    always_comb begin
        ms_int_d = 1'b0;
        if (interrupt_enable_reg_q[`UAL_IER_MS]) begin
            ms_int_d = (|delta_q[`UAL_MSR_DDCD:`UAL_MSR_DDSR])
                || (delta_q[`UAL_MSR_DCTS]
                    && (!auto_tx_flow_enable
                        || interrupt_enable_reg_q[`UAL_IER_CTS]));
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_modem_int <= 1'b0;
        end else begin
            o_modem_int <= ms_int_d;
        end
    end

    // receive side errors
    assign oe_set = i_rx_done && i_rx_fifo_full;
    // with the fifo on, parity is reported as the char reaches the head
    assign pe_set = fifo_control_reg_q[`UAL_FCR_FIFO_EN]
        ? (i_rx_head_new && i_rx_head_parity_bad)
        : (i_rx_done && i_rx_parity_bad && !i_rx_fifo_full);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rx_data_ready_q <= 1'b0;
            overrun_q <= 1'b0;
            parity_error_q <= 1'b0;
            o_rx_push <= 1'b0;
        end else begin
            rx_data_ready_q <= !i_rx_fifo_empty;
            // the full fifo is never overwritten
            o_rx_push <= i_rx_done && !i_rx_fifo_full;
            overrun_q <= oe_set || (overrun_q && !rd_lsr);
            parity_error_q <= pe_set
                || (parity_error_q && !rd_lsr);
        end
    end

    // transmit handshake back to the fifo
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_tx_pop <= 1'b0;
            o_txd <= 1'b1;
        end else begin
            o_tx_pop <= tx.take;
            o_txd <= tx.txd;
        end
    end

    // sticky interrupt status, write one to clear, new event wins
    assign irq_event[`UAL_IRQ_RDA] = !i_rx_fifo_empty && !rx_data_ready_q;
    assign irq_event[`UAL_IRQ_OE] = oe_set;
    assign irq_event[`UAL_IRQ_PE] = pe_set;
    assign irq_event[`UAL_IRQ_MS] = ms_int_d && !o_modem_int;

    always_comb begin
        irq_stat_d = irq_stat_q;
        if (i_reg_wr && (i_reg_addr == `UAL_ADDR_IRQ_STAT)) begin
            irq_stat_d = irq_stat_q & ~i_reg_wdata[`UAL_IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_d | irq_event;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            irq_stat_q <= '0;
            o_irq <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            o_irq <= |(irq_stat_d & irq_mask_q);
        end
    end
endmodule

// File: testbench/ual_monitor.sv
// port assertions of the serial status block
`include "ual_consts.svh"
module ual_monitor #(
    parameter int BAUD_DIV = `UAL_BAUD_DIV
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // register port
    input wire logic [31:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    // pins and fifo side
    input wire logic i_cts_n,
    input wire logic i_rx_done,
    input wire logic i_rx_fifo_full,
    input wire logic i_rx_fifo_empty,
    input wire logic i_rx_head_new,
    input wire logic o_tx_pop,
    input wire logic o_txd,
    input wire logic o_rx_push,
    input wire logic o_modem_int
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ms_en_q;
    logic auto_q;
    logic [15:0] hold_q;
    logic rd_lsr;
    assign rd_lsr = i_reg_rd && i_reg_addr == `UAL_ADDR_LSR;
    default clocking dc @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    always_ff @(posedge i_sys_clk) begin
        if (i_rst)
            ms_en_q <= 1'b0;
        else if (i_reg_wr && i_reg_addr == `UAL_ADDR_IER)
            ms_en_q <= i_reg_wdata[`UAL_IER_MS];
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst)
            auto_q <= 1'b0;
        else if (i_reg_wr && i_reg_addr == `UAL_ADDR_MCR)
            auto_q <= i_reg_wdata[`UAL_MCR_AUTO_CTS];
    end
    // cycles of refused cts; bound covers sync, stop midpoint and pop lag
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || !auto_q || !i_cts_n)
            hold_q <= 16'h0;
        else if (hold_q != 16'hffff)
            hold_q <= hold_q + 16'h1;
    end
    rdata_idle_a: assert property (
        !$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
        else $error("read data seen without a read");
    push_cause_a: assert property (
        o_rx_push |-> $past(i_rx_done && !i_rx_fifo_full))
        else $error("push without a char or into a full fifo");
    push_need_a: assert property (
        i_rx_done && !i_rx_fifo_full |=> o_rx_push)
        else $error("char not pushed into fifo");
    modem_off_a: assert property (
        !ms_en_q && !$past(ms_en_q) |-> !o_modem_int)
        else $error("modem interrupt while disabled");
    cts_hold_a: assert property (
        hold_q > BAUD_DIV + 8 |-> !o_tx_pop)
        else $error("byte started while cts refused");
    pop_start_a: assert property (
        o_tx_pop |-> !o_txd)
        else $error("pop without start bit");
    status_clear_a: assert property (
        rd_lsr && !i_rx_done && !i_rx_head_new ##1 rd_lsr
        |=> o_reg_rdata[2:1] == 2'b00)
        else $error("error flag survived a status read");
    clear_race_a: assert property (
        rd_lsr && i_rx_done && i_rx_fifo_full ##1 rd_lsr |=> o_reg_rdata[1])
        else $error("overrun lost to a coinciding read");
    ready_flag_a: assert property (
        $stable(i_rx_fifo_empty) [*3] ##0 rd_lsr
        |=> o_reg_rdata[0] == !$past(i_rx_fifo_empty))
        else $error("data ready differs from fifo level");
    cover property (o_tx_pop);
    cover property (rd_lsr && i_rx_done && i_rx_fifo_full);
    cover property (o_modem_int);
endmodule

// File: testbench/ual_cts_peer.sv
// remote port model that drives the clear-to-send line
module ual_cts_peer #(
    parameter int BAUD_DIV = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_txd,
    input wire logic i_pause,
    output logic o_cts_n
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = -1;
    initial o_cts_n = 1'b0;
    always @(posedge i_sys_clk) begin
        if (cnt < 0 && i_txd === 1'b0)
            cnt <= 0;
        else if (cnt >= 0)
            cnt <= (cnt == 10 * BAUD_DIV - 1) ? -1 : cnt + 1;
    end
    // raised a bit early so the sync delay still beats mid stop
    always @(posedge i_sys_clk) begin
        if (!i_pause)
            o_cts_n <= 1'b0;
        else if (cnt < 0 || cnt == 8 * BAUD_DIV)
            o_cts_n <= 1'b1;
    end
endmodule

// File: testbench/test_ual_top.sv
// bench of flow gating, modem interrupt and line status flags
`include "ual_consts.svh"
module test_ual_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BD = 8;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [31:0] i_reg_addr = 32'h0;
    logic [31:0] i_reg_wdata = 32'h0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [31:0] o_reg_rdata;
    logic i_cts_n;
    logic [3:1] pin_n = 3'h7;
    logic pause = 1'b1;
    logic i_tx_valid = 1'b0;
    logic [7:0] i_tx_data = 8'h0;
    logic [3:0] ev = 4'h0;
    logic i_rx_fifo_full = 1'b0;
    logic i_rx_fifo_empty = 1'b1;
    logic o_tx_pop, o_txd, o_rx_push, o_modem_int, o_irq;
    logic [31:0] regs [8] = '{`UAL_ADDR_MCR, `UAL_ADDR_LSR, `UAL_ADDR_IER,
        `UAL_ADDR_MSR, `UAL_ADDR_FCR, `UAL_ADDR_IRQ_STAT,
        `UAL_ADDR_IRQ_MASK, 32'h4000_8000};
    logic [15:0] cfg [4] = '{16'h0000, 16'h0800, 16'h0880, 16'h8880};
    int failures = 0;
    int checks = 0;
    int pushes = 0;
    ual_top #(.BAUD_DIV(BD)) u_ual_top (.i_sys_clk, .i_rst, .i_reg_addr,
        .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_cts_n,
        .i_dsr_n(pin_n[1]), .i_ri_n(pin_n[2]), .i_dcd_n(pin_n[3]),
        .i_tx_valid, .i_tx_data, .o_tx_pop, .o_txd, .i_rx_done(ev[3]),
        .i_rx_parity_bad(ev[2]), .i_rx_fifo_full, .i_rx_fifo_empty,
        .i_rx_head_new(ev[1]), .i_rx_head_parity_bad(ev[0]), .o_rx_push,
        .o_modem_int, .o_irq);
    ual_cts_peer #(.BAUD_DIV(BD)) u_ual_cts_peer (.i_sys_clk,
        .i_txd(o_txd), .i_pause(pause), .o_cts_n(i_cts_n));
    always #12.5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) if (o_rx_push === 1'b1) pushes++;
    task automatic cmp(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    task automatic wr_reg(input logic [31:0] a, d);
        tick(1);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        tick(1);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [31:0] a, e);
        tick(1);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        tick(1);
        i_reg_rd <= 1'b0;
        #1 cmp("reg", e, o_reg_rdata);
    endtask
    // two reads back to back; the first may meet a receive event
    task automatic lsr2(input logic [31:0] e1, e2, input logic d);
        tick(1);
        i_reg_rd <= 1'b1;
        i_reg_addr <= `UAL_ADDR_LSR;
        ev <= {d, 3'h0};
        tick(1);
        ev <= 4'h0;
        #1 cmp("lsr", e1, o_reg_rdata);
        tick(1);
        i_reg_rd <= 1'b0;
        #1 cmp("lsr", e2, o_reg_rdata);
    endtask
    task automatic rx_ev(input logic [3:0] v);
        tick(1);
        ev <= v;
        tick(1);
        ev <= 4'h0;
        tick(3);
    endtask
    // waits for a pop, then samples each bit at its middle
    task automatic recv(input logic [7:0] e, nxt, input logic more, stop);
        logic [9:0] f;
        int n;
        n = 0;
        while (o_tx_pop !== 1'b1 && n < 40 * BD) begin
            tick(1);
            #1 n++;
        end
        tick(1);
        i_tx_valid <= more;
        i_tx_data <= nxt;
        pause <= stop;
        tick(BD / 2 - 1);
        for (int i = 0; i < 10; i++) begin
            if (i > 0)
                tick(BD);
            #1 f[i] = o_txd;
        end
        cmp("frame", {1'b1, e, 1'b0}, f);
    endtask
    task automatic quiet(input int c);
        logic ok;
        ok = 1'b1;
        repeat (c) begin
            tick(1);
            #1 if (o_tx_pop !== 1'b0 || o_txd !== 1'b1) ok = 1'b0;
        end
        cmp("held", 1'b1, ok);
    endtask
    task automatic wiggle(input int k);
        repeat (2) begin
            tick(1);
            if (k == 0)
                pause <= !pause;
            else
                pin_n[k] <= !pin_n[k];
            tick(8);
        end
        tick(2);
        #1;
    endtask
    task automatic final_report;
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #(20000 * 25);
        failures++;
        final_report();
    end
    initial begin
        tick(12);
        i_rst <= 1'b0;
        foreach (regs[i]) rd_reg(regs[i], 32'h0);
        wr_reg(`UAL_ADDR_LSR, 32'hff);
        wr_reg(32'h4000_8000, 32'hff);
        rd_reg(`UAL_ADDR_LSR, 32'h0);
        wr_reg(`UAL_ADDR_MCR, 32'h80);
        rd_reg(`UAL_ADDR_MCR, 32'h80);
        tick(1);
        pause <= 1'b1;
        tick(8);
        i_tx_valid <= 1'b1;
        i_tx_data <= 8'ha5;
        quiet(40);
        pause <= 1'b0;
        recv(8'ha5, 8'h3c, 1'b1, 1'b1);
        quiet(60);
        pause <= 1'b0;
        recv(8'h3c, 8'h0, 1'b0, 1'b0);
        wr_reg(`UAL_ADDR_MCR, 32'h0);
        tick(1);
        pause <= 1'b1;
        tick(8);
        i_tx_valid <= 1'b1;
        i_tx_data <= 8'h81;
        recv(8'h81, 8'h0, 1'b0, 1'b0);
        rd_reg(`UAL_ADDR_MSR, 32'h11);
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 4; k++) begin
                wr_reg(`UAL_ADDR_IER, {24'h0, cfg[c][15:8]});
                wr_reg(`UAL_ADDR_MCR, {24'h0, cfg[c][7:0]});
                wiggle(k);
                cmp("mint", cfg[c][11] && (k > 0 || !cfg[c][7] ||
                    cfg[c][15]), o_modem_int);
                rd_reg(`UAL_ADDR_MSR, 32'h10 | (32'h1 << k));
                tick(3);
                #1 cmp("mint", 1'b0, o_modem_int);
            end
        end
        tick(1);
        i_rx_fifo_empty <= 1'b0;
        lsr2(32'h1, 32'h1, 1'b0);
        i_rx_fifo_full <= 1'b1;
        rx_ev(4'h8);
        lsr2(32'h3, 32'h1, 1'b0);
        i_rx_fifo_full <= 1'b0;
        rx_ev(4'hc);
        lsr2(32'h5, 32'h1, 1'b0);
        wr_reg(`UAL_ADDR_FCR, 32'h1);
        rx_ev(4'hc);
        lsr2(32'h1, 32'h1, 1'b0);
        rx_ev(4'h3);
        lsr2(32'h5, 32'h1, 1'b0);
        i_rx_fifo_full <= 1'b1;
        lsr2(32'h1, 32'h3, 1'b1);
        cmp("push", 32'h2, pushes);
        wr_reg(`UAL_ADDR_IRQ_STAT, 32'hf);
        wr_reg(`UAL_ADDR_IRQ_MASK, 32'h2);
        rx_ev(4'h8);
        #1 cmp("irq", 1'b1, o_irq);
        rd_reg(`UAL_ADDR_IRQ_STAT, 32'h2);
        wr_reg(`UAL_ADDR_IRQ_STAT, 32'h2);
        tick(1);
        #1 cmp("irq", 1'b0, o_irq);
        wr_reg(`UAL_ADDR_IRQ_MASK, 32'h0);
        rx_ev(4'h8);
        #1 cmp("irq", 1'b0, o_irq);
        rd_reg(`UAL_ADDR_IRQ_STAT, 32'h2);
        i_rx_fifo_empty <= 1'b1;
        tick(4);
        lsr2(32'h2, 32'h0, 1'b0);
        final_report();
    end
endmodule
bind ual_top ual_monitor #(.BAUD_DIV(BAUD_DIV)) u_ual_monitor (.i_sys_clk,
    .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_cts_n, .i_rx_done, .i_rx_fifo_full, .i_rx_fifo_empty, .i_rx_head_new,
    .o_tx_pop, .o_txd, .o_rx_push, .o_modem_int);
